// *** dtt_engine.sv ***
// Two-channel DMA engine: termination, start timing and bus sharing
// Behaviour
// R1: Cutoff option set: active fast interrupt clears global enable.
// R2: Fast-interrupt stop takes effect at the end of the current item.
// R3: Fast-interrupt stop is local, independent of interrupt controller.
// R4: Writing 0 to a channel enable stops and disables that channel.
// R5: Writing 0 to global enable stops and disables both channels.
// R6: Transfer starts at least two cycles after the request cycle.
// R7: Waiting channel raises bus request the cycle after the request.
// R8: Every access goes through the memory controller, which sets length.
// R9: Wide write to 8-bit peripheral passes only the low byte.
// R10: Wide read from 8-bit peripheral replicates the byte to both halves.
// R11: Requesting interrupt waits for burst end, or one item.
// R12: Slow acknowledged device stretches access with the wait pin.
// R13: Level-sensed burst requester holds its request until burst end.
// R14: Level-sensed pin bursts never pause on request release.
// R15: Clearing software start in cycle steal stops after one more item.
// R16: Bus release request: give up bus after the current access.
// R17: Resume the interrupted transfer once the bus is granted again.
// R18: Software never targets the engine's own registers by DMA.
// R19: No bus grant while the CPU runs an atomic swap.
// R20: Requests keep being served in the halt state.
// R21: Count reaching zero ends transfer and sets the end flag.
// R22: Count end clears only that channel enable, not the global one.
// R23: Count end raises an interrupt request if its enable is 1.
// R24: Clearing global enable restores channel 0 priority, keeps scheme.
// R25: Cutoff option clear: fast interrupt has no effect at all.
// R26: Forced stop completes the item in flight, no partial item.
`timescale 1ns/100ps
module dtt_engine
  import dtt_pkg::*;
(
  input  wire logic        sys_clk,      // System clock
  input  wire logic        rst_n,        // Synchronous reset
  input  wire logic [7:0]  regAddr,      // Register byte address
  input  wire logic [31:0] regWdata,     // Register write data
  input  wire logic        regWr,        // Write strobe
  input  wire logic        regRd,        // Read strobe
  output logic      [31:0] regRdata,     // Read data, cycle after strobe
  input  wire logic        fastIntPin_n, // Fast interrupt pin
  input  wire logic        busRelReq_n,  // External bus release request pin
  input  wire logic [1:0]  extReq_n,     // External request pins
  input  wire logic [1:0]  periphReq,    // On-chip peripheral requests
  output logic             busReq,       // Bus request to arbiter
  input  wire logic        busGrant,     // Bus granted
  input  wire logic        swapBusy,     // CPU in atomic swap
  output dtt_acc_type      acc,          // Access to memory controller
  input  wire logic        accDone,      // Access finished
  input  wire logic [15:0] accRdata,     // Access read data
  input  wire logic        narrowRd,     // Read target is 8-bit peripheral
  input  wire logic        narrowWr,     // Write target is 8-bit peripheral
  output logic      [1:0]  chanIrq,      // Count end interrupt requests
  output logic      [1:0]  irqHold       // Hold requesting interrupt
);

  dtt_regs_type r;
  dtt_regs_type n;
  logic [1:0]   req;
  logic         pick;
  logic         fiqAct;
  logic         brAct;
  logic         stop;
  logic         cont;

  assign fiqAct = !r.fiqLvl;
  assign brAct  = !r.brLvl;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n      = r;
    req    = '0;
    pick   = 1'b0;
    stop   = 1'b0;
    cont   = 1'b0;
    n.rdata = '0;

    // Pins: three flops, a change counts when the last two agree
    n.fiqS = {r.fiqS[1:0], fastIntPin_n};
    n.brS  = {r.brS[1:0], busRelReq_n};
    if (r.fiqS[2] == r.fiqS[1]) begin
      n.fiqLvl = r.fiqS[2];
    end
    if (r.brS[2] == r.brS[1]) begin
      n.brLvl = r.brS[2];
    end

    // Halt mode is not an input: requests are served regardless
    for (int c = 0; c < 2; c++) begin
      n.rqS[c] = {r.rqS[c][1:0], extReq_n[c]};
      if (r.rqS[c][2] == r.rqS[c][1]) begin
        n.rqLvl[c] = r.rqS[c][2];
      end
      case (r.ch[c].src)
        SRC_SW:  req[c] = r.ch[c].sw | r.ch[c].swTail;
        SRC_PIN: req[c] = !r.rqLvl[c];
        SRC_PER: req[c] = periphReq[c];
        default: req[c] = 1'b0;
      endcase
      req[c] = req[c] & r.ch[c].en & r.gEn; // R20
    end

    // Register writes
    if (regWr) begin
      if (regAddr == ADDR_CMD) begin
        n.gEn = regWdata[CMD_GEN]; // R5
        n.cut = regWdata[CMD_CUT];
        n.rr  = regWdata[CMD_RR];
        n.ie  = regWdata[CMD_IE+:2];
      end
      if (regAddr == ADDR_END) begin
        n.endFlg = r.endFlg & ~regWdata[1:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (regAddr == ADDR_MODE[c]) begin
          n.ch[c].en    = regWdata[MODE_EN]; // R4
          n.ch[c].sw    = regWdata[MODE_SW];
          n.ch[c].burst = regWdata[MODE_BURST];
          n.ch[c].wide  = regWdata[MODE_WIDE];
          n.ch[c].src   = regWdata[MODE_SRC+:2];
          if (r.ch[c].sw && !regWdata[MODE_SW] && !r.ch[c].burst) begin
            n.ch[c].swTail = r.ch[c].en; // R15
          end
        end
        if (regAddr == ADDR_CNT[c]) begin
          n.ch[c].cnt = regWdata[15:0];
        end
      end
    end

    // Reads
    if (regRd) begin
      case (regAddr)
        ADDR_CMD:     n.rdata = {27'h0, r.ie, r.rr, r.cut, r.gEn};
        ADDR_END:     n.rdata = {30'h0, r.endFlg};
        ADDR_STAT:    n.rdata = {26'h0, r.prioCh1, r.pendWr, r.cur, r.st};
        ADDR_MODE[0]: n.rdata = {26'h0, r.ch[0].src, r.ch[0].wide,
                                 r.ch[0].burst, r.ch[0].sw, r.ch[0].en};
        ADDR_MODE[1]: n.rdata = {26'h0, r.ch[1].src, r.ch[1].wide,
                                 r.ch[1].burst, r.ch[1].sw, r.ch[1].en};
        ADDR_CNT[0]:  n.rdata = {16'h0, r.ch[0].cnt};
        ADDR_CNT[1]:  n.rdata = {16'h0, r.ch[1].cnt};
        default:      n.rdata = '0;
      endcase
    end

    // Cutoff acts straight from the pin, no interrupt controller involved
    if (r.cut && fiqAct) begin
      n.gEn = 1'b0; // R1 R3 R25
    end

    // Transfer sequencing
    pick = req[1] && (!req[0] || (r.rr && r.prioCh1));
    case (r.st)
      ST_IDLE: begin
        if (|req) begin
          n.cur    = pick;
          n.pendWr = 1'b0;
          n.st     = ST_ARB; // R7
        end
      end
      ST_ARB: begin
        if (!r.pendWr && !(n.ch[r.cur].en && n.gEn)) begin
          n.st = ST_IDLE;
        end else if (busGrant && !swapBusy && !brAct) begin
          n.st = r.pendWr ? ST_WR : ST_RD; // R6 R17 R19
        end
      end
      ST_RD: begin
        if (accDone) begin
          n.data = accRdata;
          if (narrowRd && r.ch[r.cur].wide) begin
            n.data = {accRdata[7:0], accRdata[7:0]}; // R10
          end
          n.pendWr = brAct;
          n.st     = brAct ? ST_ARB : ST_WR; // R8 R16
        end
      end
      ST_WR: begin
        if (accDone) begin
          n.pendWr = 1'b0;
          n.ch[r.cur].cnt    = r.ch[r.cur].cnt - 16'h0001;
          n.ch[r.cur].swTail = 1'b0;
          if (r.rr) begin
            n.prioCh1 = !r.cur;
          end
          if (r.ch[r.cur].cnt == 16'h0001) begin
            n.ch[r.cur].en     = 1'b0; // R21 R22
            n.endFlg[r.cur]    = 1'b1; // R21
          end
          // Enables are checked here and in ST_ARB with no write pending, so the item in flight completes
          stop = !n.ch[r.cur].en || !n.gEn; // R2 R26
          // Pin requests never pause a burst; the requester holds it
          cont = r.ch[r.cur].burst &&
                 !(r.ch[r.cur].src == SRC_PER && !periphReq[r.cur]); // R13 R14
          if (stop || !cont) begin
            n.st = ST_IDLE;
          end else begin
            n.st = brAct ? ST_ARB : ST_RD; // R16
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (!n.gEn) begin
      n.prioCh1 = 1'b0; // R24
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r        <= '0;
      r.fiqS   <= SYNC_IDLE;
      r.brS    <= SYNC_IDLE;
      r.rqS    <= {SYNC_IDLE, SYNC_IDLE};
      r.fiqLvl <= 1'b1;
      r.brLvl  <= 1'b1;
      r.rqLvl  <= 2'h3;
      r.ch[0].cnt <= CNT_RST;
      r.ch[1].cnt <= CNT_RST;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign regRdata   = r.rdata;
  assign busReq     = (r.st == ST_ARB && !brAct) || r.st == ST_RD || r.st == ST_WR;
  assign acc.req    = r.st == ST_RD || r.st == ST_WR; // R8
  assign acc.write  = r.st == ST_WR;
  assign acc.chan   = r.cur;
  assign acc.data   = r.data;
  // A narrow write target sees the low lane only
  assign acc.byteEn = (r.st == ST_WR && (narrowWr || !r.ch[r.cur].wide)) ?
                      2'h1 : 2'h3; // R9

  for (genvar g = 0; g < 2; g++) begin : gen_chan
    assign chanIrq[g] = r.endFlg[g] & r.ie[g]; // R23
    // Held for the whole burst, or for one item in cycle steal
    assign irqHold[g] = r.st != ST_IDLE && r.cur == 1'(g); // R11
  end

  // ------------------------------------------------------------
  // Start latency helper
  // ------------------------------------------------------------
  // Cycles since the engine left idle; saturates so long bursts stay cheap
  logic [1:0] startAge;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      startAge <= 2'h0;
    end else if (r.st == ST_IDLE) begin
      startAge <= 2'h0;
    end else if (startAge != 2'h3) begin
      startAge <= startAge + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_arb_next: assert property (r.st == ST_IDLE && |req |=> busReq) // R7
    else $error("bus request not raised after request");
  a_start_late: assert property (r.st == ST_IDLE |=> !acc.req) // R6
    else $error("access started too early");
  a_fiq_cut: assert property (r.cut && fiqAct |=> !r.gEn ##1 !r.gEn) // R1
    else $error("fast interrupt did not clear global enable");
  a_fiq_ignored: assert property (!r.cut && !(regWr && regAddr == ADDR_CMD)
    |=> r.gEn == $past(r.gEn)) // R25
    else $error("global enable changed without cause");
  a_count_end: assert property (r.st == ST_WR && accDone && r.ch[r.cur].cnt == 16'h0001
    && !(regWr && regAddr == ADDR_MODE[r.cur])
    |=> r.endFlg[$past(r.cur)] && !r.ch[$past(r.cur)].en && r.st == ST_IDLE) // R21
    else $error("count end not handled");
  a_keep_global: assert property (r.st == ST_WR && accDone && r.ch[r.cur].cnt == 16'h0001
    && !r.cut && !regWr |=> r.gEn == $past(r.gEn)) // R22
    else $error("count end touched global enable");
  a_swap_wait: assert property (r.st == ST_ARB && swapBusy |=> r.st != ST_RD && r.st != ST_WR)
    else $error("bus taken during atomic swap"); // R19
  a_bus_yield: assert property (acc.req && accDone && brAct |=> !busReq) // R16
    else $error("bus not yielded after access");
  a_resume_wr: assert property (r.st == ST_RD && accDone && brAct
    |=> r.pendWr throughout (r.st == ST_ARB)[*1]) // R17
    else $error("pending write lost");
  a_replicate: assert property (r.st == ST_RD && accDone && narrowRd && r.ch[r.cur].wide
    |=> r.data[15:8] == r.data[7:0]) // R10
    else $error("narrow read not replicated");
  a_narrow_wr: assert property (acc.write && narrowWr |-> acc.byteEn == 2'h1) // R9
    else $error("narrow write drives upper lane");
  a_item_stop: assert property (r.st == ST_WR && accDone && !n.gEn |=> r.st == ST_IDLE)
    else $error("transfer continued after stop"); // R2
  a_chan_off: assert property (regWr && regAddr == ADDR_MODE[0] && !regWdata[MODE_EN]
    |=> !r.ch[0].en) // R4
    else $error("channel enable not cleared");
  a_prio_reset: assert property (!r.gEn |-> !r.prioCh1) // R24
    else $error("priority not restored");
  a_start_age: assert property (acc.req |-> startAge >= 2'(MIN_START_CYC - 1)) // R6
    else $error("access before start latency");

  // Stop, yield, tail, halt, pin burst, interrupt, end flag and read data behaviour
  a_access_hold: assert property (acc.req && !accDone // R26
    |=> acc.req && acc.write == $past(acc.write))
    else $error("access dropped before done");
  a_halt_serve: assert property (r.st == ST_IDLE && r.ch[0].en && r.gEn // R20
    && r.ch[0].src == SRC_PER && periphReq[0] |=> r.st == ST_ARB)
    else $error("request not served");
  a_yield_hold: assert property (r.st == ST_ARB && brAct |=> !acc.req) // R16
    else $error("access during bus release");
  a_cut_stop: assert property (r.st == ST_WR && accDone && r.cut && fiqAct // R2
    |=> r.st == ST_IDLE)
    else $error("burst not stopped by fast interrupt");
  a_tail_item: assert property (r.st == ST_IDLE && r.ch[0].swTail && r.ch[0].en // R15
    && r.gEn && r.ch[0].src == SRC_SW |=> r.st == ST_ARB)
    else $error("tail item not started");
  a_pin_burst: assert property (r.st == ST_WR && accDone && r.ch[r.cur].burst // R14
    && r.ch[r.cur].src == SRC_PIN && r.ch[r.cur].cnt != 16'h0001 && r.ch[r.cur].en
    && r.gEn && !(r.cut && fiqAct) && !brAct && !regWr |=> r.st == ST_RD)
    else $error("pin burst paused");
  a_irq_raise: assert property (r.st == ST_WR && accDone && r.ch[r.cur].cnt == 16'h0001 // R23
    && r.ie[r.cur] && !regWr |=> chanIrq[$past(r.cur)])
    else $error("count end interrupt missing");
  a_end_sticky: assert property (r.endFlg[0] && !(regWr && regAddr == ADDR_END) // R21
    |=> r.endFlg[0])
    else $error("end flag lost");
  a_rd_idle: assert property (!regRd |=> regRdata == 32'h0) // R18
    else $error("read data without strobe");

  c_burst: cover property (r.st == ST_WR && accDone ##1 r.st == ST_RD);
  c_fiq: cover property (r.cut && fiqAct && r.st == ST_RD);
  c_yield: cover property (r.pendWr && r.st == ST_ARB ##[1:20] r.st == ST_WR);
  c_end: cover property (r.endFlg[1] && r.ie[1]);
  c_tail: cover property (r.ch[0].swTail && r.st == ST_RD);

endmodule

// *** dtt_pkg.sv ***
// Package: register map, field layout, states and carriers of the DMA termination engine
package dtt_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]      ADDR_CMD  = 8'h00;
  localparam logic [7:0]      ADDR_END  = 8'h04;
  localparam logic [7:0]      ADDR_STAT = 8'h08;
  localparam logic [1:0][7:0] ADDR_MODE = {8'h14, 8'h10};
  localparam logic [1:0][7:0] ADDR_CNT  = {8'h1c, 8'h18};

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CMD_GEN    = 0;
  localparam int CMD_CUT    = 1;
  localparam int CMD_RR     = 2;
  localparam int CMD_IE     = 3;
  localparam int MODE_EN    = 0;
  localparam int MODE_SW    = 1;
  localparam int MODE_BURST = 2;
  localparam int MODE_WIDE  = 3;
  localparam int MODE_SRC   = 4;

  localparam logic [1:0] SRC_SW  = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_PER = 2'h2;

  // Reset values and timing
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [2:0]  SYNC_IDLE     = 3'h7;
  localparam int          MIN_START_CYC = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB  = 3'h1,
    ST_RD   = 3'h3,
    ST_WR   = 3'h2
  } dtt_state_type;

  typedef struct packed {
    logic        en;
    logic        sw;
    logic        swTail;
    logic        burst;
    logic        wide;
    logic [1:0]  src;
    logic [15:0] cnt;
  } dtt_chan_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        chan;
    logic [1:0]  byteEn;
    logic [15:0] data;
  } dtt_acc_type;

  typedef struct packed {
    dtt_chan_type [1:0] ch;
    logic               gEn;
    logic               cut;
    logic               rr;
    logic [1:0]         ie;
    logic [1:0]         endFlg;
    logic               prioCh1;
    dtt_state_type      st;
    logic               cur;
    logic               pendWr;
    logic [15:0]        data;
    logic [31:0]        rdata;
    logic [2:0]         fiqS;
    logic [2:0]         brS;
    logic [1:0][2:0]    rqS;
    logic               fiqLvl;
    logic               brLvl;
    logic [1:0]         rqLvl;
  } dtt_regs_type;

endpackage

// *** dtt_mem_model.sv ***
// Behavioural bus arbiter and memory controller facing the DMA engine
`timescale 1ns/100ps
module dtt_mem_model
  import dtt_pkg::*;
(
  input  wire logic        sys_clk,  // System clock
  input  wire logic        rst_n,    // Synchronous reset
  input  wire logic        busReq,   // Engine bus request
  input  wire logic        swapBusy, // CPU in atomic swap
  input  wire dtt_acc_type acc,      // Engine access
  input  wire logic [3:0]  waitCyc,  // Wait cycles per access
  input  wire logic [15:0] rdVal,    // Value returned by reads
  output logic             busGrant, // Bus granted
  output logic             accDone,  // Access finished pulse
  output logic      [15:0] accRdata, // Read data
  output logic      [7:0]  rdCnt,    // Finished reads
  output logic      [7:0]  wrCnt,    // Finished writes
  output logic      [15:0] lastData, // Data of last write
  output logic      [1:0]  lastBe    // Byte enables of last write
);
  logic [3:0]  waitCnt;
  logic [15:0] noise;

  // Read data is only meaningful with the done pulse; elsewhere it keeps moving
  assign accRdata = (accDone && !acc.write) ? rdVal : noise;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busGrant <= 1'b0;
      accDone  <= 1'b0;
      waitCnt  <= 4'h0;
      noise    <= 16'h5a3c;
      rdCnt    <= 8'h00;
      wrCnt    <= 8'h00;
      lastData <= 16'h0000;
      lastBe   <= 2'h0;
    end else begin
      noise    <= noise + 16'h3b1d;
      busGrant <= busReq && (busGrant || !swapBusy);
      accDone  <= 1'b0;
      if (acc.req && !accDone) begin
        if (waitCnt == waitCyc) begin
          accDone <= 1'b1;
          waitCnt <= 4'h0;
          if (acc.write) begin
            wrCnt    <= wrCnt + 8'h01;
            lastData <= acc.data;
            lastBe   <= acc.byteEn;
          end else begin
            rdCnt <= rdCnt + 8'h01;
          end
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

// *** dtt_tb.sv ***
// Self-checking testbench for the DMA termination engine
`timescale 1ns/100ps
module tb
  import dtt_pkg::*;
();
  localparam logic [31:0] C_GEN = 32'h1 << CMD_GEN;
  localparam logic [31:0] C_CUT = 32'h1 << CMD_CUT;
  localparam logic [31:0] C_RR  = 32'h1 << CMD_RR;
  localparam logic [31:0] C_IE0 = 32'h1 << CMD_IE;
  logic        sys_clk, rst_n, regWr, regRd, fastIntPin_n, busRelReq_n, busReq;
  logic        busGrant, swapBusy, accDone, narrowRd, narrowWr, hit;
  logic [7:0]  regAddr, rdCnt, wrCnt, w0, r0;
  logic [31:0] regWdata, regRdata, rdata;
  logic [1:0]  periphReq, chanIrq, irqHold, lastBe, extReq_n;
  logic [15:0] accRdata, rdVal, lastData;
  logic [3:0]  waitCyc;
  dtt_acc_type acc;
  int          n_mismatch, checked;

  dtt_engine i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fastIntPin_n(fastIntPin_n),
    .busRelReq_n(busRelReq_n), .extReq_n(extReq_n), .periphReq(periphReq), .busReq(busReq),
    .busGrant(busGrant), .swapBusy(swapBusy), .acc(acc), .accDone(accDone),
    .accRdata(accRdata), .narrowRd(narrowRd), .narrowWr(narrowWr), .chanIrq(chanIrq),
    .irqHold(irqHold));
  dtt_mem_model i_mem (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .swapBusy(swapBusy),
    .acc(acc), .waitCyc(waitCyc), .rdVal(rdVal), .busGrant(busGrant), .accDone(accDone),
    .accRdata(accRdata), .rdCnt(rdCnt), .wrCnt(wrCnt), .lastData(lastData), .lastBe(lastBe));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rdata = regRdata;
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] mval(input logic sw, input logic burst, input logic [1:0] src);
    mval = 32'h0;
    mval[MODE_EN] = 1'b1;
    mval[MODE_SW] = sw;
    mval[MODE_BURST] = burst;
    mval[MODE_WIDE] = 1'b1;
    mval[MODE_SRC +: 2] = src;
  endfunction
  // Mode goes last so the channel cannot start before count and command are set
  task start(input logic [15:0] cnt, input logic [31:0] mode, input logic [31:0] cmd);
    w0 = wrCnt;
    r0 = rdCnt;
    wr(ADDR_CNT[0], {16'h0, cnt});
    wr(ADDR_CMD, cmd);
    wr(ADDR_MODE[0], mode);
  endtask
  task wait_idle();
    int i;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 3000 && irqHold !== 2'b00; i++) @(negedge sys_clk);
    chk(irqHold, 0);
    @(posedge sys_clk);
  endtask
  task wait_wr();
    int i;
    for (i = 0; i < 500 && wrCnt == w0; i++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset();
    rd(ADDR_CMD);
    chk(rdata, 0);
    rd(ADDR_STAT);
    chk(rdata, 0);
    rd(8'hfc);
    chk(rdata, 0);
    $display("test reset done");
  endtask
  task t_start();
    start(16'h0002, mval(1'b0, 1'b1, SRC_PER), C_GEN | C_RR | C_IE0);
    periphReq[0] <= 1'b1;
    @(posedge sys_clk);
    #1 chk(busReq, 1);
    chk(acc.req, 0);
    wait_idle();
    periphReq[0] <= 1'b0;
    chk(8'(wrCnt - w0), 2);
    chk(lastData, rdVal);
    rd(ADDR_END);
    chk(rdata, 1);
    rd(ADDR_MODE[0]);
    chk(rdata[MODE_EN], 0);
    rd(ADDR_CMD);
    chk(rdata[CMD_GEN], 1);
    chk(chanIrq, 2'b01);
    wr(ADDR_CMD, C_RR);
    rd(ADDR_STAT);
    chk(rdata[5], 0);
    rd(ADDR_CMD);
    chk(rdata[CMD_RR], 1);
    wr(ADDR_END, 32'h1);
    rd(ADDR_END);
    chk(rdata, 0);
    $display("test start and count end done");
  endtask
  task t_narrow();
    narrowRd <= 1'b1;
    narrowWr <= 1'b1;
    start(16'h0001, mval(1'b1, 1'b0, SRC_SW), C_GEN);
    wait_idle();
    chk(lastData, {rdVal[7:0], rdVal[7:0]});
    chk(lastBe, 2'b01);
    narrowRd <= 1'b0;
    narrowWr <= 1'b0;
    $display("test narrow peripheral done");
  endtask
  task t_cut();
    for (int c = 0; c < 2; c++) begin
      start(16'h0006, mval(1'b1, 1'b1, SRC_SW), C_GEN | (c ? C_CUT : 32'h0));
      wait_wr();
      fastIntPin_n <= 1'b0;
      wait_idle();
      fastIntPin_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rd(ADDR_CMD);
      chk(rdata[CMD_GEN], c ? 32'h0 : 32'h1);
      chk(8'(wrCnt - w0) < 8'h06, c ? 32'h1 : 32'h0);
      chk(8'(rdCnt - r0), 8'(wrCnt - w0));
    end
    $display("test fast interrupt done");
  endtask
  task t_force();
    for (int k = 0; k < 2; k++) begin
      start(16'h0000, mval(1'b1, 1'b1, SRC_SW), C_GEN);
      wait_wr();
      if (k == 0) wr(ADDR_MODE[0], 32'h0);
      else wr(ADDR_CMD, 32'h0);
      wait_idle();
      chk(8'(rdCnt - r0), 8'(wrCnt - w0));
      repeat (4) @(posedge sys_clk);
      chk(busReq, 0);
      rd(ADDR_STAT);
      chk(rdata[2:0], 0);
    end
    $display("test forced stop done");
  endtask
  // Second pass drops the pin early: the burst must still run to its end
  task t_pin();
    for (int p = 0; p < 2; p++) begin
      start(16'h0003, mval(1'b0, 1'b1, SRC_PIN), C_GEN);
      extReq_n[0] <= 1'b0;
      wait_wr();
      if (p == 1) extReq_n[0] <= 1'b1;
      wait_idle();
      extReq_n[0] <= 1'b1;
      chk(8'(wrCnt - w0), 3);
    end
    $display("test pin burst done");
  endtask
  task t_share();
    int i;
    swapBusy <= 1'b1;
    start(16'h0003, mval(1'b1, 1'b1, SRC_SW), C_GEN);
    hit = 1'b0;
    repeat (20) begin
      @(negedge sys_clk);
      hit |= acc.req;
    end
    chk(hit, 0);
    chk(irqHold, 2'b01);
    @(posedge sys_clk);
    swapBusy <= 1'b0;
    wait_wr();
    busRelReq_n <= 1'b0;
    for (i = 0; i < 60 && busReq !== 1'b0; i++) @(negedge sys_clk);
    chk(busReq, 0);
    hit = 1'b0;
    repeat (10) begin
      @(negedge sys_clk);
      hit |= acc.req;
    end
    chk(hit, 0);
    @(posedge sys_clk);
    busRelReq_n <= 1'b1;
    wait_idle();
    chk(8'(wrCnt - w0), 3);
    chk(8'(rdCnt - r0), 3);
    $display("test bus sharing done");
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    fastIntPin_n = 1'b1;
    busRelReq_n = 1'b1;
    periphReq = 2'b00;
    extReq_n = 2'b11;
    swapBusy = 1'b0;
    narrowRd = 1'b0;
    narrowWr = 1'b0;
    waitCyc = 4'h2;
    rdVal = 16'hc3a5;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_start();
    t_narrow();
    t_cut();
    t_force();
    t_pin();
    t_share();
    finish_test();
  end
endmodule
